// *** eep_pkg.sv ***
// Shared constants for the two-wire EEPROM front end and its bus master
package eep_pkg;
   localparam logic [3:0] EEP_TYPE_ARRAY  = 4'h5;  // Arbitrary type identifier value
   localparam logic [3:0] EEP_TYPE_IDPAGE = 4'h4;  // Arbitrary; differs from array only in b4
   localparam int         EEP_TYPE_MSB    = 7;
   localparam int         EEP_TYPE_LSB    = 4;
   localparam int         EEP_CS_MSB      = 3;
   localparam int         EEP_CS_LSB      = 1;
   localparam int         EEP_RW_BIT      = 0;
   localparam logic       EEP_RW_READ     = 1'b1;
   localparam logic [2:0] EEP_BIT_LAST    = 3'h7;
   localparam int         EEP_CLK_NS      = 8;
   localparam int         EEP_WRITE_NS    = 5000;
   localparam int         EEP_WRITE_CYC   = (EEP_WRITE_NS + EEP_CLK_NS - 1) / EEP_CLK_NS;
   localparam int         EEP_HALF_NS     = 500;
   localparam int         EEP_HALF_CYC    = EEP_HALF_NS / EEP_CLK_NS;
   typedef enum logic [2:0] {EEP_M_CMD_WRITE, EEP_M_CMD_READ} eep_cmd_t;
endpackage : eep_pkg

// *** eep_bus_if.sv ***
// Two-wire bus carrier joining the bus master and the EEPROM front end
`timescale 1ns/1ns
`default_nettype none
interface eep_bus_if;
   logic scl;
   logic sda_o_dev;
   logic sda_oe_dev;
   logic sda_o_mst;
   logic sda_oe_mst;
   // Open drain: wired low if either side drives low, else pulled up
   wire  sda = !((sda_oe_dev && !sda_o_dev) || (sda_oe_mst && !sda_o_mst));
   modport dev (input scl, input sda, output sda_o_dev, output sda_oe_dev);
   modport mst (output scl, input sda, output sda_o_mst, output sda_oe_mst);
endinterface : eep_bus_if
`default_nettype wire

// *** eep_slave.sv ***
// EEPROM bus front end: start/stop, select decode, address, acknowledge, protection
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Protect pin high from start through address blocks every array write
// - Floating protect pin reads low, writes allowed
// - Protected: ack select and address, not data
// - Reset release gives standby; ignore during reset
// - Reset assertion stops all responses at once
// - Master ends with stop before power off
// - Select byte: type, chip select, read flag
// - Second type value selects identification page
// - Two address bytes form 16-bit address
// - Start is SDA fall with SCL high
// - Stop is SDA rise with SCL high
// - Master no-ack then stop ends read
// - Stop after write starts write cycle
// - Receiver pulls SDA low on ninth pulse
// - Device never drives SCL nor starts
// - Read flag one reads, zero writes
// - Match acks; mismatch leaves bus till start
// - Sample SDA on SCL rising edge
// - Floating chip selects compare as low
module eep_slave
   import eep_pkg::*;
#(
   parameter int WRITE_CYC = EEP_WRITE_CYC
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // Straps; pull-downs modelled outside, a floating pin arrives as low
   input  wire logic        write_protect_n,
   input  wire logic [2:0]  chip_select_pins,
   // Bus
   eep_bus_if.dev           bus,
   // User side
   output logic [15:0]      byte_addr,
   output logic [7:0]       wr_data,
   output logic             wr_strobe,
   output logic             id_page,
   output logic             rd_mode,
   input  wire logic [7:0]  rd_data,
   output logic             busy
);
   typedef enum logic [2:0] {EEP_IDLE, EEP_SEL, EEP_ADH, EEP_ADL, EEP_DATA, EEP_RD} eep_st_t;
   eep_st_t     st;
   logic [1:0]  scl_s;
   logic [1:0]  sda_s;
   logic        scl_q;
   logic        sda_q;
   logic [2:0]  bitn;
   logic [7:0]  shreg;
   logic        ack_slot;
   logic        ack_live;
   logic        give_ack;
   logic        drive_low;
   logic        wp;
   logic        wr_seen;
   logic        nack_m;
   logic [31:0] busy_cnt;
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // First stage feeds only the second, so a metastable level never reaches the decode
   always_ff @(posedge clock) begin
      scl_s <= {scl_s[0], bus.scl};
      sda_s <= {sda_s[0], bus.sda};
      scl_q <= scl_s[1];
      sda_q <= sda_s[1];
   end
   // ----------------------------------------
   // Bus conditions and select decode
   // ----------------------------------------
   wire       scl       = scl_s[1];
   wire       sda       = sda_s[1];
   wire       scl_r     = scl && !scl_q;
   wire       scl_f     = !scl && scl_q;
   wire       start     = scl && scl_q && sda_q && !sda;
   wire       stop      = scl && scl_q && !sda_q && sda;
   wire [7:0] byte_in   = {shreg[6:0], sda};
   wire [3:0] type_id   = byte_in[EEP_TYPE_MSB:EEP_TYPE_LSB];
   // select decode; floating chip selects arrive low
   wire       cs_ok     = byte_in[EEP_CS_MSB:EEP_CS_LSB] == chip_select_pins;
   wire       is_id     = type_id == EEP_TYPE_IDPAGE;
   wire       sel_ok    = cs_ok && (type_id == EEP_TYPE_ARRAY || is_id);
   wire       rd_sel    = byte_in[EEP_RW_BIT] == EEP_RW_READ;
   wire       byte_done = scl_r && bitn == EEP_BIT_LAST && !ack_slot;
   // ----------------------------------------
   // Bus outputs
   // ----------------------------------------
   // write cycle busy
   assign busy = busy_cnt != 32'h0;
   // SCL is never driven; open-drain low only
   assign bus.sda_o_dev  = 1'b0;
   assign bus.sda_oe_dev = drive_low && !rst && !busy;
   // ----------------------------------------
   // Protocol engine
   // ----------------------------------------
   always_ff @(posedge clock) begin
      wr_strobe <= 1'b0;
      // reset returns to standby; responses stop at once
      if (rst) begin
         st        <= EEP_IDLE;
         bitn      <= 3'h0;
         shreg     <= 8'h0;
         ack_slot  <= 1'b0;
         ack_live  <= 1'b0;
         give_ack  <= 1'b0;
         drive_low <= 1'b0;
         wp        <= 1'b0;
         wr_seen   <= 1'b0;
         nack_m    <= 1'b0;
         busy_cnt  <= 32'h0;
         byte_addr <= 16'h0;
         wr_data   <= 8'h0;
         id_page   <= 1'b0;
         rd_mode   <= 1'b0;
      end else if (busy) begin
         // no start watching during the write cycle
         busy_cnt <= busy_cnt - 32'h1;
      end else if (stop) begin
         st        <= EEP_IDLE;
         drive_low <= 1'b0;
         ack_slot  <= 1'b0;
         ack_live  <= 1'b0;
         wr_seen   <= 1'b0;
         // stop after an accepted data byte starts the write cycle
         if (wr_seen) begin
            busy_cnt <= 32'(WRITE_CYC);
         end
      end else if (start) begin
         // protect sampled from start through address
         st        <= EEP_SEL;
         bitn      <= 3'h0;
         ack_slot  <= 1'b0;
         ack_live  <= 1'b0;
         drive_low <= 1'b0;
         wp        <= write_protect_n;
         wr_seen   <= 1'b0;
      end else if (st != EEP_IDLE) begin
         if (st inside {EEP_SEL, EEP_ADH, EEP_ADL}) begin
            wp <= wp | write_protect_n;
         end
         if (scl_r && !ack_slot) begin
            shreg <= byte_in;
            bitn  <= bitn + 3'h1;
         end
         // the master's answer to a byte we sent
         if (scl_r && ack_slot && st == EEP_RD) begin
            nack_m <= sda;
         end
         if (byte_done) begin
            ack_slot <= 1'b1;
            unique case (st)
               EEP_SEL: begin
                  give_ack <= sel_ok;
                  if (!sel_ok) begin
                     st <= EEP_IDLE;
                  end else begin
                     id_page <= is_id;
                     rd_mode <= rd_sel;
                     st      <= rd_sel ? EEP_RD : EEP_ADH;
                  end
               end
               // address high then low; both acked even when protected
               EEP_ADH: begin
                  byte_addr[15:8] <= byte_in;
                  give_ack        <= 1'b1;
                  st              <= EEP_ADL;
               end
               EEP_ADL: begin
                  byte_addr[7:0] <= byte_in;
                  give_ack       <= 1'b1;
                  st             <= EEP_DATA;
               end
               EEP_DATA: begin
                  // protected data neither stored nor acked
                  give_ack <= !wp;
                  if (!wp) begin
                     wr_data   <= byte_in;
                     wr_strobe <= 1'b1;
                     wr_seen   <= 1'b1;
                  end
               end
               // Byte sent by us: the master owns the ninth slot
               EEP_RD: begin
                  give_ack <= 1'b0;
               end
               default: begin
                  st <= EEP_IDLE;
               end
            endcase
         end
         // first fall of the slot takes SDA, the second hands it back
         if (scl_f && ack_slot && bitn == 3'h0) begin
            if (!ack_live) begin
               ack_live  <= 1'b1;
               drive_low <= give_ack;
            end else begin
               ack_slot  <= 1'b0;
               ack_live  <= 1'b0;
               drive_low <= 1'b0;
               if (st == EEP_RD && nack_m) begin
                  st <= EEP_IDLE;
               end
               // Next byte out, most significant bit first
               if (st == EEP_RD && !nack_m) begin
                  shreg     <= rd_data;
                  drive_low <= !rd_data[7];
               end
            end
         end
         // The receive shift moves each next bit into the top place
         if (scl_f && !ack_slot && st == EEP_RD && bitn != 3'h0) begin
            drive_low <= !shreg[7];
         end
      end
   end
endmodule : eep_slave
`default_nettype wire

// *** eep_master.sv ***
// Simple bus master: start, select, two address bytes, one data byte, stop
`timescale 1ns/1ns
`default_nettype none
module eep_master
   import eep_pkg::*;
#(
   parameter int HALF_CYC = EEP_HALF_CYC
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // Bus
   eep_bus_if.mst           bus,
   // User side
   input  wire logic        go,
   input  wire logic [7:0]  sel,
   input  wire logic [15:0] addr,
   input  wire logic [7:0]  data,
   output logic             done,
   output logic             acked
);
   typedef enum logic [2:0] {EEP_M_IDLE, EEP_M_START, EEP_M_BIT, EEP_M_STOP} eep_mst_t;
   eep_mst_t    st;
   logic [35:0] sh;
   logic [5:0]  n;
   logic [31:0] cnt;
   logic [1:0]  ph;
   logic [1:0]  sda_s;
   wire tick = cnt == 32'h0;
   // master alone drives SCL; data changes while SCL low
   always_ff @(posedge clock) begin
      sda_s <= {sda_s[0], bus.sda};
      done  <= 1'b0;
      if (rst) begin
         st <= EEP_M_IDLE; bus.scl <= 1'b1; bus.sda_o_mst <= 1'b1; bus.sda_oe_mst <= 1'b0;
         sh <= 36'h0; n <= 6'h0; cnt <= 32'h0; ph <= 2'h0; acked <= 1'b1;
      end else begin
         cnt <= tick ? 32'(HALF_CYC) : cnt - 32'h1;
         if (tick) unique case (st)
            EEP_M_IDLE: if (go) begin
               // release SDA in each ninth slot
               sh <= {sel, 1'b1, addr[15:8], 1'b1, addr[7:0], 1'b1, data, 1'b1};
               st <= EEP_M_START; acked <= 1'b1; n <= 6'h0;
            end
            EEP_M_START: begin
               bus.sda_oe_mst <= 1'b1; bus.sda_o_mst <= 1'b0; st <= EEP_M_BIT; ph <= 2'h0;
            end
            EEP_M_BIT: begin
               ph <= ph + 2'h1;
               if (ph == 2'h0) bus.scl <= 1'b0;
               if (ph == 2'h1) begin bus.sda_o_mst <= sh[35]; bus.sda_oe_mst <= !sh[35]; end
               if (ph == 2'h2) bus.scl <= 1'b1;
               if (ph == 2'h3) begin
                  if (n == 6'd8 || n == 6'd17 || n == 6'd26 || n == 6'd35) acked <= acked & !sda_s[1];
                  sh <= {sh[34:0], 1'b1}; n <= n + 6'h1;
                  if (n == 6'd35) begin st <= EEP_M_STOP; ph <= 2'h0; end
               end
            end
            EEP_M_STOP: begin
               ph <= ph + 2'h1;
               if (ph == 2'h0) bus.scl <= 1'b0;
               if (ph == 2'h1) begin bus.sda_oe_mst <= 1'b1; bus.sda_o_mst <= 1'b0; end
               if (ph == 2'h2) bus.scl <= 1'b1;
               if (ph == 2'h3) begin bus.sda_oe_mst <= 1'b0; bus.sda_o_mst <= 1'b1; st <= EEP_M_IDLE; done <= 1'b1; end
            end
            default: st <= EEP_M_IDLE;
         endcase
      end
   end
endmodule : eep_master
`default_nettype wire

// *** eep_assertions.sv ***
// Bus protocol checker for the EEPROM front end
`timescale 1ns/1ns
`default_nettype none
module eep_assertions #(
   parameter int WRITE_CYC = 20
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Bus and user side
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_o_dev,
   input wire logic sda_oe_dev,
   input wire logic write_protect_n,
   input wire logic wr_strobe,
   input wire logic busy
);
   logic [15:0] bcnt;
   always_ff @(posedge clock) begin
      bcnt <= (rst || !busy) ? 16'h0 : bcnt + 16'h1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // ----
   // Properties
   // ----
   a_prot_no_strobe: assert property (write_protect_n |-> !wr_strobe)
      else $error("strobe while protected");
   a_busy_no_ack: assert property (busy |-> !sda_oe_dev)
      else $error("bus driven while busy");
   a_reset_quiet: assert property (disable iff (1'b0) rst |=> !sda_oe_dev && !busy)
      else $error("activity under reset");
   a_drive_scl_low: assert property ($rose(sda_oe_dev) |-> !scl)
      else $error("sda taken while scl high");
   a_free_scl_low: assert property ($fell(sda_oe_dev) |-> !scl)
      else $error("sda released while scl high");
   a_sda_steady: assert property (scl && $past(scl) && sda_oe_dev |-> $stable(sda_oe_dev) && $stable(sda_o_dev))
      else $error("sda moved while scl high");
   a_stop_quiet: assert property ($rose(sda) && scl && $past(scl) |=> !sda_oe_dev [*8])
      else $error("drive after stop");
   a_busy_after_stop: assert property ($rose(busy) |-> scl && sda)
      else $error("write cycle without stop");
   a_busy_length: assert property ($fell(busy) |-> bcnt == 16'(WRITE_CYC))
      else $error("write cycle length wrong");
   c_strobe: cover property (wr_strobe);
   c_ack: cover property (sda_oe_dev && !sda_o_dev);
   c_busy: cover property ($rose(busy));
endmodule : eep_assertions
`default_nettype wire

// *** eeprom_i2c_slave_front_end_bench.sv ***
// Bench joining the bus master and the EEPROM front end
`timescale 1ns/1ns
`default_nettype none
module eeprom_i2c_slave_front_end_bench;
   import eep_pkg::*;
   // Long write cycle so a second frame lands inside it
   localparam int WC = 400;
   typedef struct packed {logic [7:0] s; logic [2:0] c; logic w, ea, es, ei;} eep_row_t;
   logic        clock = 1'b0, rst = 1'b1, write_protect_n = 1'b0, go = 1'b0;
   logic        done, acked, wr_strobe, id_page, busy, rd_mode;
   logic [2:0]  chip_select_pins = 3'h0;
   logic [7:0]  sel = 8'h0, wr_data;
   logic [15:0] byte_addr;
   int          miscompares = 0, checks = 0, strobes = 0, busy_cyc = 0;
   eep_row_t    b;
   eep_row_t    rows [7] = '{'{{EEP_TYPE_ARRAY, 3'h3, 1'b0}, 3'h3, 1'b0, 1'b1, 1'b1, 1'b0},
      '{{EEP_TYPE_IDPAGE, 3'h3, 1'b0}, 3'h3, 1'b0, 1'b1, 1'b1, 1'b1},
      '{{EEP_TYPE_ARRAY, 3'h0, 1'b0}, 3'h0, 1'b0, 1'b1, 1'b1, 1'b0},
      '{{EEP_TYPE_ARRAY, 3'h3, 1'b0}, 3'h3, 1'b1, 1'b0, 1'b0, 1'b0},
      '{{EEP_TYPE_ARRAY, 3'h2, 1'b0}, 3'h3, 1'b0, 1'b0, 1'b0, 1'b0},
      '{{~EEP_TYPE_ARRAY, 3'h3, 1'b0}, 3'h3, 1'b0, 1'b0, 1'b0, 1'b0},
      '{{EEP_TYPE_ARRAY, 3'h3, 1'b1}, 3'h3, 1'b0, 1'b0, 1'b0, 1'b0}};
   eep_bus_if bus ();
   eep_slave #(.WRITE_CYC(WC)) u_eep_slave (.clock(clock), .rst(rst), .write_protect_n(write_protect_n),
      .chip_select_pins(chip_select_pins), .bus(bus.dev), .byte_addr(byte_addr), .wr_data(wr_data),
      .wr_strobe(wr_strobe), .id_page(id_page), .rd_mode(rd_mode), .rd_data(8'hA5), .busy(busy));
   eep_master #(.HALF_CYC(4)) u_eep_master (.clock(clock), .rst(rst), .bus(bus.mst), .go(go), .sel(sel),
      .addr(16'h80C1), .data(8'h3C), .done(done), .acked(acked));
   eep_assertions #(.WRITE_CYC(WC)) u_eep_assertions (.clock(clock), .rst(rst), .scl(bus.scl), .sda(bus.sda),
      .sda_o_dev(bus.sda_o_dev), .sda_oe_dev(bus.sda_oe_dev), .write_protect_n(write_protect_n),
      .wr_strobe(wr_strobe), .busy(busy));
   always #4 clock = ~clock;
   always @(posedge clock) begin
      if (wr_strobe === 1'b1) strobes <= strobes + 1;
      if (busy === 1'b1) busy_cyc <= busy_cyc + 1;
   end
   // ----
   // Tasks
   // ----
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] v);
      checks++;
      if (v !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, v);
      end
   endtask : chk
   task automatic results();
      if (miscompares == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results
   // Negative eb skips the write cycle count and leaves it running on
   task automatic run(input eep_row_t r, input int eb);
      int n;
      n = 0;
      @(negedge clock);
      write_protect_n = r.w;
      chip_select_pins = r.c;
      sel = r.s;
      go = 1'b1;
      strobes = 0;
      while (done !== 1'b1 && n < 5000) begin
         @(negedge clock);
         n++;
      end
      go = 1'b0;
      chk("acked", 16'(r.ea), 16'(acked));
      chk("strobes", 16'(r.es), strobes[15:0]);
      chk("rd_mode", 16'(r.s[0]), 16'(rd_mode));
      if (r.es) begin
         chk("byte_addr", 16'h80C1, byte_addr);
         chk("wr_data", 16'h3C, 16'(wr_data));
         chk("id_page", 16'(r.ei), 16'(id_page));
      end
      if (eb >= 0) begin
         repeat (WC + 50) @(negedge clock);
         chk("busy", eb[15:0], busy_cyc[15:0]);
         busy_cyc = 0;
      end
   endtask : run
   initial begin
      repeat (10) @(negedge clock);
      rst = 1'b0;
      foreach (rows[i]) run(rows[i], rows[i].es ? WC : 0);
      b = rows[0];
      b.ea = 1'b0;
      b.es = 1'b0;
      run(rows[0], -1);
      run(b, WC);
      go = 1'b1;
      repeat (100) @(negedge clock);
      rst = 1'b1;
      repeat (3) @(negedge clock);
      chk("sda_oe_dev", 16'h0, 16'(bus.sda_oe_dev));
      chk("busy_rst", 16'h0, 16'(busy));
      go = 1'b0;
      rst = 1'b0;
      run(rows[0], WC);
      results();
   end
   initial begin
      repeat (40000) @(posedge clock);
      miscompares++;
      results();
   end
endmodule : eeprom_i2c_slave_front_end_bench
`default_nettype wire
